// file: hw/tseg_pkg.sv
// Purpose: Shared constants for the timer software event block.
// Assumes: One 100 MHz clock, AHB-Lite register access.
// Notes: Registers are 16 bits wide, one aligned 32-bit word each.
package tseg_pkg;
  // Register byte offsets.
  localparam logic [7:0] A_EVT = 8'h00;
  localparam logic [7:0] A_CTRL = 8'h04;
  localparam logic [7:0] A_PSC = 8'h08;
  localparam logic [7:0] A_ARR = 8'h0C;
  localparam logic [7:0] A_CNT = 8'h10;
  localparam logic [7:0] A_PRE = 8'h14;
  localparam logic [7:0] A_ACT = 8'h18;
  localparam logic [7:0] A_CAP1 = 8'h1C;
  localparam logic [7:0] A_CAP2 = 8'h20;
  localparam logic [7:0] A_CAP3 = 8'h24;
  localparam logic [7:0] A_STAT = 8'h28;
  localparam logic [7:0] A_IEN = 8'h2C;
  localparam logic [7:0] A_DEN = 8'h30;
  // Event generation bits.
  localparam int B_UG = 0;
  localparam int B_CHANNEL1_EVENT_FORCE = 1;
  localparam int B_COMMUTATION_UPDATE_FORCE = 5;
  localparam int B_TG = 6;
  localparam int B_BG = 7;
  localparam logic [15:0] EVT_MASK = 16'h00EF;
  // Status bits (sticky, write one to clear).
  localparam int S_UIF = 0;
  localparam int S_CHANNEL1_FLAG = 1;
  localparam int S_COMIF = 5;
  localparam int S_TIF = 6;
  localparam int S_BIF = 7;
  localparam int S_CHANNEL1_OVERCAPTURE_FLAG = 9;
  localparam logic [15:0] STAT_MASK = 16'h0EEF;
  // Control register fields.
  localparam int C_MODE = 0;
  localparam int C_UPDATE_DISABLE = 2;
  localparam int C_URS = 3;
  localparam int C_CONTROL_PRELOAD_ON = 4;
  localparam int C_IN1 = 5;
  localparam int C_MOE = 8;
  localparam logic [15:0] CTRL_MASK = 16'h01FF;
  // Per-channel control: enable, complementary enable, three mode bits.
  localparam int CH_W = 5;
  localparam int NCH = 3;
  // Value of every register after reset.
  localparam logic [15:0] RST_VAL = 16'h0000;
  typedef enum logic [1:0] {
    CM_UP = 2'b00,
    CM_DOWN = 2'b01,
    CM_CENTER = 2'b10
  } tseg_cmode_t;
  typedef enum logic {
    BS_IDLE = 1'b0,
    BS_WAIT = 1'b1
  } tseg_bst_t;
endpackage

// file: hw/tseg_reg_if.sv
// Purpose: Register access path between the bus slave and the timer core.
// Assumes: Same clock on both sides.
// Notes: Read data is combinational from the addressed register.
`timescale 1ns/1ps
`default_nettype none
interface tseg_reg_if;
  logic wrEn;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [15:0] rdata;
  modport slave (output wrEn, output addr, output wdata, input rdata);
  modport regs (input wrEn, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// file: hw/tseg_ahb_slave.sv
// Purpose: AHB-Lite slave with one wait state on every transfer.
// Assumes: Single word transfers, response always OKAY.
// Notes: The wait state lets read data leave straight from a flip-flop.
`timescale 1ns/1ps
`default_nettype none
module tseg_ahb_slave (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  tseg_reg_if.slave bus
);
  typedef struct packed {
    tseg_pkg::tseg_bst_t st;
    logic wr;
    logic [7:0] addr;
    logic rdy;
    logic [31:0] rdata;
  } tseg_bstate_t;
  tseg_bstate_t s_r, s_nxt;

  // Address phase is taken only while ready; data phase lasts two cycles.
  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      tseg_pkg::BS_IDLE: begin
        if (hsel && htrans[1] && hready) begin
          s_nxt.st = tseg_pkg::BS_WAIT;
          s_nxt.wr = hwrite;
          s_nxt.addr = {haddr[7:2], 2'b00};
          s_nxt.rdy = 1'b0;
        end
      end
      tseg_pkg::BS_WAIT: begin
        s_nxt.st = tseg_pkg::BS_IDLE;
        s_nxt.rdy = 1'b1;
        s_nxt.rdata = s_r.wr ? 32'h0000_0000 : {16'h0000, bus.rdata};
      end
      default: s_nxt = s_r;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.rdy <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Writes land in the cycle where hwdata is valid.
  assign bus.wrEn = (s_r.st == tseg_pkg::BS_WAIT) && s_r.wr;
  assign bus.addr = s_r.addr;
  assign bus.wdata = hwdata;
  assign hreadyout = s_r.rdy;
  assign hrdata = s_r.rdata;

  sequence s_addrPh;
    hsel && htrans[1] && hready;
  endsequence
  sequence s_dataPh;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_slvTiming;
    @(posedge clk) disable iff (!nrst) s_addrPh |=> s_dataPh;
  endproperty
  a_slvTiming: assert property (p_slvTiming) else $error("Slave wait state wrong.");
endmodule // tseg_ahb_slave
`default_nettype wire

// file: hw/tseg_top.sv
// Purpose: Software event generation for a 16-bit control timer.
// Assumes: AHB-Lite register access, 100 MHz clk, synchronous nrst.
// Notes: A small counter core is included so forced events act on it.
// Summary of operation
// RULE_01: Brake bit write clears main output enable, sets brake flag, requests irq/DMA.
// RULE_02: Trigger bit write sets trigger flag, requests irq/DMA, then self-clears.
// RULE_03: Commutation bit with preload on loads channel enables and modes, then self-clears.
// RULE_04: Commutation loads only the three complementary channels.
// RULE_05: Channel 2 and 3 bits act like channel 1 for their direction.
// RULE_06: Channel 1 output: bit sets channel 1 flag, requests irq/DMA.
// RULE_07: Channel 1 input: bit captures counter, sets flag, requests irq/DMA.
// RULE_08: Forced capture with channel 1 flag already set sets over-capture.
// RULE_09: Channel and trigger bits are one-shot and clear after their event.
// RULE_10: Update bit reinitialises the counter, makes update event, self-clears.
// RULE_11: Forced update zeroes prescaler count, keeps the division ratio.
// RULE_12: Forced update: zero when up or center, reload value when down.
// RULE_13: Forced update flag only when updates enabled and source permits software.
// RULE_14: Event register reads zero; reserved bits ignore writes.
`timescale 1ns/1ps
`default_nettype none
module tseg_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic mainOutEn,
  output logic [14:0] chanCtl,
  output logic irq,
  output logic [15:0] dmaReq
);
  typedef struct packed {
    logic [15:0] gen;
    logic brk;
    logic [15:0] ctrl;
    logic [15:0] psc;
    logic [15:0] arr;
    logic [15:0] pscCnt;
    logic [15:0] cnt;
    logic cntDown;
    logic [14:0] pre;
    logic [14:0] act;
    logic [2:0][15:0] cap;
    logic [15:0] stat;
    logic [15:0] ien;
    logic [15:0] den;
    logic irq;
    logic [15:0] dma;
  } tseg_state_t;
  tseg_state_t s_r, s_nxt;
  tseg_reg_if bus ();
  logic [15:0] ev;
  logic [15:0] w1c;
  logic ovf;
  logic hsizeUnused;

  // Only word transfers exist, so the size is not decoded.
  assign hsizeUnused = ^hsize;

  tseg_ahb_slave u_slave (
    .clk(clk),
    .nrst(nrst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .bus(bus.slave)
  );

  // Next state: register writes first, then counter, then forced events.
  always_comb begin
    s_nxt = s_r;
    ev = '0;
    w1c = '0;
    ovf = 1'b0;
    s_nxt.gen = '0; // see RULE_09
    if (bus.wrEn) begin
      case (bus.addr)
        tseg_pkg::A_EVT: begin
          s_nxt.gen = bus.wdata[15:0] & tseg_pkg::EVT_MASK; // see RULE_14
          s_nxt.brk = bus.wdata[tseg_pkg::B_BG]; // see RULE_01
        end
        tseg_pkg::A_CTRL: s_nxt.ctrl = bus.wdata[15:0] & tseg_pkg::CTRL_MASK;
        tseg_pkg::A_PSC: s_nxt.psc = bus.wdata[15:0];
        tseg_pkg::A_ARR: s_nxt.arr = bus.wdata[15:0];
        tseg_pkg::A_PRE: s_nxt.pre = bus.wdata[14:0];
        tseg_pkg::A_STAT: w1c = bus.wdata[15:0];
        tseg_pkg::A_IEN: s_nxt.ien = bus.wdata[15:0] & tseg_pkg::STAT_MASK;
        tseg_pkg::A_DEN: s_nxt.den = bus.wdata[15:0] & tseg_pkg::STAT_MASK;
        default: ;
      endcase
    end

    // Prescaler and counter. Center mode counts up to reload, then down.
    if (s_r.pscCnt >= s_r.psc) begin
      s_nxt.pscCnt = '0;
      case (tseg_pkg::tseg_cmode_t'(s_r.ctrl[1:0]))
        tseg_pkg::CM_UP: begin
          ovf = (s_r.cnt >= s_r.arr);
          s_nxt.cnt = ovf ? 16'h0000 : s_r.cnt + 16'h0001;
        end
        tseg_pkg::CM_DOWN: begin
          ovf = (s_r.cnt == 16'h0000);
          s_nxt.cnt = ovf ? s_r.arr : s_r.cnt - 16'h0001;
        end
        tseg_pkg::CM_CENTER: begin
          if (!s_r.cntDown && s_r.cnt >= s_r.arr) begin
            ovf = 1'b1;
            s_nxt.cntDown = 1'b1;
            s_nxt.cnt = (s_r.arr == 16'h0000) ? 16'h0000 : s_r.cnt - 16'h0001;
          end else if (s_r.cntDown && s_r.cnt == 16'h0000) begin
            ovf = 1'b1;
            s_nxt.cntDown = 1'b0;
            s_nxt.cnt = 16'h0001;
          end else if (s_r.cntDown) begin
            s_nxt.cnt = s_r.cnt - 16'h0001;
          end else begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
          end
        end
        default: s_nxt.cnt = s_r.cnt;
      endcase
    end else begin
      s_nxt.pscCnt = s_r.pscCnt + 16'h0001;
    end
    if (ovf && !s_r.ctrl[tseg_pkg::C_UPDATE_DISABLE]) begin
      ev[tseg_pkg::S_UIF] = 1'b1;
    end

    // Forced update restarts the count; the division ratio psc is untouched.
    if (s_r.gen[tseg_pkg::B_UG]) begin
      s_nxt.pscCnt = '0; // see RULE_11
      s_nxt.cntDown = 1'b0;
      if (s_r.ctrl[1:0] == tseg_pkg::CM_DOWN) begin
        s_nxt.cnt = s_r.arr; // see RULE_12
      end else begin
        s_nxt.cnt = '0; // see RULE_12
      end
      if (!s_r.ctrl[tseg_pkg::C_UPDATE_DISABLE] && !s_r.ctrl[tseg_pkg::C_URS]) begin
        ev[tseg_pkg::S_UIF] = 1'b1; // see RULE_10, RULE_13
      end
    end

    // Commutation copies preloaded controls of channels 1 to 3 only.
    if (s_r.gen[tseg_pkg::B_COMMUTATION_UPDATE_FORCE]) begin
      ev[tseg_pkg::S_COMIF] = 1'b1;
      if (s_r.ctrl[tseg_pkg::C_CONTROL_PRELOAD_ON]) begin
        s_nxt.act = s_r.pre; // see RULE_03, RULE_04
      end
    end

    if (s_r.gen[tseg_pkg::B_TG]) begin
      ev[tseg_pkg::S_TIF] = 1'b1; // see RULE_02
    end

    // Brake: the flag sets on the write of one; the held bit keeps outputs off.
    if (s_r.gen[tseg_pkg::B_BG]) begin
      ev[tseg_pkg::S_BIF] = 1'b1; // see RULE_01
    end
    if (s_r.gen[tseg_pkg::B_BG] || s_r.brk) begin
      s_nxt.ctrl[tseg_pkg::C_MOE] = 1'b0; // see RULE_01
    end

    // Channel events; an input channel captures the counter first.
    for (int i = 0; i < tseg_pkg::NCH; i++) begin
      if (s_r.gen[tseg_pkg::B_CHANNEL1_EVENT_FORCE + i]) begin
        ev[tseg_pkg::S_CHANNEL1_FLAG + i] = 1'b1; // see RULE_05, RULE_06
        if (s_r.ctrl[tseg_pkg::C_IN1 + i]) begin
          s_nxt.cap[i] = s_r.cnt; // see RULE_07
          if (s_r.stat[tseg_pkg::S_CHANNEL1_FLAG + i]) begin
            ev[tseg_pkg::S_CHANNEL1_OVERCAPTURE_FLAG + i] = 1'b1; // see RULE_08
          end
        end
      end
    end

    // A hardware set wins over a clear written in the same cycle.
    s_nxt.stat = ((s_r.stat & ~w1c) | ev) & tseg_pkg::STAT_MASK;
    s_nxt.irq = |(s_nxt.stat & s_nxt.ien);
    s_nxt.dma = ev & s_nxt.den;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Read mux; the event register always reads zero.
  always_comb begin
    case (bus.addr)
      tseg_pkg::A_EVT: bus.rdata = tseg_pkg::RST_VAL; // see RULE_14
      tseg_pkg::A_CTRL: bus.rdata = s_r.ctrl;
      tseg_pkg::A_PSC: bus.rdata = s_r.psc;
      tseg_pkg::A_ARR: bus.rdata = s_r.arr;
      tseg_pkg::A_CNT: bus.rdata = s_r.cnt;
      tseg_pkg::A_PRE: bus.rdata = {1'b0, s_r.pre};
      tseg_pkg::A_ACT: bus.rdata = {1'b0, s_r.act};
      tseg_pkg::A_CAP1: bus.rdata = s_r.cap[0];
      tseg_pkg::A_CAP2: bus.rdata = s_r.cap[1];
      tseg_pkg::A_CAP3: bus.rdata = s_r.cap[2];
      tseg_pkg::A_STAT: bus.rdata = s_r.stat;
      tseg_pkg::A_IEN: bus.rdata = s_r.ien;
      tseg_pkg::A_DEN: bus.rdata = s_r.den;
      default: bus.rdata = tseg_pkg::RST_VAL;
    endcase
  end

  // Outputs other than the tied-low hresp are taken straight from state flip-flops.
  assign hresp = 1'b0;
  assign mainOutEn = s_r.ctrl[tseg_pkg::C_MOE];
  assign chanCtl = s_r.act;
  assign irq = s_r.irq;
  assign dmaReq = s_r.dma;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  property p_brake;
    s_r.gen[tseg_pkg::B_BG] |=> s_r.stat[tseg_pkg::S_BIF] && !mainOutEn;
  endproperty
  a_brake: assert property (p_brake) else $error("Brake event lost."); // see RULE_01

  property p_trig;
    s_r.gen[tseg_pkg::B_TG] && !bus.wrEn
      |=> s_r.stat[tseg_pkg::S_TIF] && !s_r.gen[tseg_pkg::B_TG];
  endproperty
  a_trig: assert property (p_trig) else $error("Trigger not set or not cleared."); // see RULE_02

  property p_com;
    s_r.gen[tseg_pkg::B_COMMUTATION_UPDATE_FORCE] && s_r.ctrl[tseg_pkg::C_CONTROL_PRELOAD_ON] |=> chanCtl == $past(s_r.pre);
  endproperty
  a_com: assert property (p_com) else $error("Commutation load wrong."); // see RULE_03

  property p_ch1Out;
    s_r.gen[tseg_pkg::B_CHANNEL1_EVENT_FORCE] && !s_r.ctrl[tseg_pkg::C_IN1]
      |=> s_r.stat[tseg_pkg::S_CHANNEL1_FLAG] && $stable(s_r.cap[0]);
  endproperty
  a_ch1Out: assert property (p_ch1Out) else $error("Output channel event wrong."); // see RULE_06

  property p_cap;
    s_r.gen[tseg_pkg::B_CHANNEL1_EVENT_FORCE] && s_r.ctrl[tseg_pkg::C_IN1]
      |=> s_r.cap[0] == $past(s_r.cnt) && s_r.stat[tseg_pkg::S_CHANNEL1_FLAG];
  endproperty
  a_cap: assert property (p_cap) else $error("Capture wrong."); // see RULE_07

  property p_ovc;
    s_r.gen[tseg_pkg::B_CHANNEL1_EVENT_FORCE] && s_r.ctrl[tseg_pkg::C_IN1] && s_r.stat[tseg_pkg::S_CHANNEL1_FLAG]
      |=> s_r.stat[tseg_pkg::S_CHANNEL1_OVERCAPTURE_FLAG];
  endproperty
  a_ovc: assert property (p_ovc) else $error("Over-capture missed."); // see RULE_08

  property p_ch3;
    s_r.gen[tseg_pkg::B_CHANNEL1_EVENT_FORCE + 2] |=> s_r.stat[tseg_pkg::S_CHANNEL1_FLAG + 2];
  endproperty
  a_ch3: assert property (p_ch3) else $error("Channel 3 event lost."); // see RULE_05

  property p_ugDown;
    s_r.gen[tseg_pkg::B_UG] && s_r.ctrl[1:0] == tseg_pkg::CM_DOWN
      |=> s_r.cnt == $past(s_r.arr) && s_r.pscCnt == 16'h0000;
  endproperty
  a_ugDown: assert property (p_ugDown) else $error("Down reload wrong."); // see RULE_12

  property p_ugUp;
    s_r.gen[tseg_pkg::B_UG] && s_r.ctrl[1:0] != tseg_pkg::CM_DOWN
      |=> s_r.cnt == 16'h0000 && s_r.pscCnt == 16'h0000 && $stable(s_r.psc);
  endproperty
  a_ugUp: assert property (p_ugUp) else $error("Update restart wrong."); // see RULE_11

  property p_ugFlag;
    s_r.gen[tseg_pkg::B_UG] && s_r.ctrl[tseg_pkg::C_UPDATE_DISABLE] && !s_r.stat[tseg_pkg::S_UIF]
      |=> !s_r.stat[tseg_pkg::S_UIF];
  endproperty
  a_ugFlag: assert property (p_ugFlag) else $error("Update flag set while disabled."); // see RULE_13

  property p_irq;
    ##1 irq == |(s_r.stat & s_r.ien);
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt level wrong.");
endmodule // tseg_top
`default_nettype wire

// file: verification/tb_timer_software_event_gen.sv
// Purpose: Self-checking bench for the timer software event block.
// Assumes: One AHB-Lite master in the bench, one wait state per transfer.
// Notes: The prescaler is set to its largest ratio so the counter stays still.
`timescale 1ns/1ps
`default_nettype none
module tb_timer_software_event_gen;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic mainOutEn;
  logic [14:0] chanCtl;
  logic irq;
  logic [15:0] dmaReq;
  int err_total = 0;
  int checks = 0;

  tseg_top tseg_top_inst (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .mainOutEn(mainOutEn), .chanCtl(chanCtl), .irq(irq), .dmaReq(dmaReq));

  // Free running 100 MHz clock.
  always #5 clk = ~clk;

  // Prints the verdict and ends the run.
  task automatic end_of_test();
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One single AHB transfer; waits are bounded so a stuck slave is reported.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    r = hrdata;
    if (n >= 40) begin
      chk(32'h0000_0000, 32'h0000_0001, "bus wait");
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0000_0000, r);
    chk(r, exp, what);
  endtask

  // The write lands one edge before the bus task returns, and the event acts
  // at the returning edge; look just after it, while the one-cycle DMA pulse stands.
  task automatic evt(input logic [15:0] bits);
    wr(tseg_pkg::A_EVT, {16'h0000, bits});
    #1;
  endtask

  // Reset values and the zero read-back of the event register.
  task automatic t_reset();
    rd(tseg_pkg::A_EVT, 32'h0000_0000, "evt reset");
    rd(tseg_pkg::A_STAT, 32'h0000_0000, "stat reset");
    rd(8'h3C, 32'h0000_0000, "unmapped read");
    chk({31'h0, mainOutEn}, 32'h0000_0000, "moe reset");
  endtask

  // Brake clears the main output enable, flags, interrupts and asks for DMA.
  task automatic t_brake();
    wr(tseg_pkg::A_CTRL, 32'h0000_0100);
    wr(tseg_pkg::A_IEN, 32'h0000_0080);
    wr(tseg_pkg::A_DEN, 32'h0000_0080);
    chk({31'h0, mainOutEn}, 32'h0000_0001, "moe set");
    evt(16'h0080);
    chk({16'h0, dmaReq}, 32'h0000_0080, "brake dma");
    chk({31'h0, mainOutEn}, 32'h0000_0000, "brake moe");
    chk({31'h0, irq}, 32'h0000_0001, "brake irq");
    rd(tseg_pkg::A_STAT, 32'h0000_0080, "brake flag");
    evt(16'h0000);
    wr(tseg_pkg::A_STAT, 32'h0000_FFFF);
    @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
  endtask

  // Trigger flags, asks for DMA, and the bit does not read back.
  task automatic t_trigger();
    wr(tseg_pkg::A_DEN, 32'h0000_0040);
    evt(16'h0040);
    chk({16'h0, dmaReq}, 32'h0000_0040, "trig dma");
    @(posedge clk);
    #1;
    chk({16'h0, dmaReq}, 32'h0000_0000, "trig one shot");
    rd(tseg_pkg::A_EVT, 32'h0000_0000, "evt reads zero");
    rd(tseg_pkg::A_STAT, 32'h0000_0040, "trig flag");
    wr(tseg_pkg::A_STAT, 32'h0000_FFFF);
    evt(16'hFF10);
    rd(tseg_pkg::A_STAT, 32'h0000_0000, "reserved bits");
  endtask

  // Output channels: the three forced events together set exactly their three flags.
  task automatic t_channels();
    wr(tseg_pkg::A_DEN, 32'h0000_000E);
    evt(16'h000E);
    chk({16'h0, dmaReq}, 32'h0000_000E, "chan dma");
    rd(tseg_pkg::A_STAT, 32'h0000_000E, "chan flags");
    wr(tseg_pkg::A_STAT, 32'h0000_FFFF);
  endtask

  // Forced update: gated flag, counter restart, ratio kept.
  task automatic t_update();
    wr(tseg_pkg::A_CTRL, 32'h0000_0004);
    evt(16'h0001);
    rd(tseg_pkg::A_STAT, 32'h0000_0000, "update_disable no flag");
    wr(tseg_pkg::A_CTRL, 32'h0000_0008);
    evt(16'h0001);
    rd(tseg_pkg::A_STAT, 32'h0000_0000, "urs no flag");
    wr(tseg_pkg::A_CTRL, 32'h0000_0002);
    evt(16'h0001);
    rd(tseg_pkg::A_CNT, 32'h0000_0000, "center zero");
    wr(tseg_pkg::A_CTRL, 32'h0000_0000);
    evt(16'h0001);
    rd(tseg_pkg::A_STAT, 32'h0000_0001, "update flag");
    rd(tseg_pkg::A_CNT, 32'h0000_0000, "up zero");
    rd(tseg_pkg::A_PSC, 32'h0000_FFFF, "ratio kept");
    wr(tseg_pkg::A_STAT, 32'h0000_FFFF);
  endtask

  // Input capture in down mode, then over-capture on a second event.
  task automatic t_capture();
    wr(tseg_pkg::A_ARR, 32'h0000_1234);
    wr(tseg_pkg::A_CTRL, 32'h0000_0021);
    evt(16'h0001);
    rd(tseg_pkg::A_CNT, 32'h0000_1234, "down reload");
    wr(tseg_pkg::A_STAT, 32'h0000_FFFF);
    evt(16'h0002);
    rd(tseg_pkg::A_CAP1, 32'h0000_1234, "capture");
    rd(tseg_pkg::A_STAT, 32'h0000_0002, "capture flag");
    evt(16'h0002);
    rd(tseg_pkg::A_STAT, 32'h0000_0202, "over capture");
    wr(tseg_pkg::A_STAT, 32'h0000_FFFF);
  endtask

  // Commutation loads the three channels only with preload on.
  task automatic t_commute();
    wr(tseg_pkg::A_CTRL, 32'h0000_0010);
    wr(tseg_pkg::A_PRE, 32'h0000_2A5A);
    chk({17'h0, chanCtl}, 32'h0000_0000, "no early load");
    evt(16'h0020);
    chk({17'h0, chanCtl}, 32'h0000_2A5A, "com load");
    wr(tseg_pkg::A_CTRL, 32'h0000_0000);
    wr(tseg_pkg::A_PRE, 32'h0000_1111);
    evt(16'h0020);
    chk({17'h0, chanCtl}, 32'h0000_2A5A, "preload off");
    rd(tseg_pkg::A_ACT, 32'h0000_2A5A, "applied read");
  endtask

  // Watchdog: the whole sequence needs a few hundred cycles.
  initial begin
    #200000;
    err_total++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    // A zero ratio after reset makes the counter wrap every cycle and set the
    // update flag, so the counter is stilled and the flags cleared first.
    wr(tseg_pkg::A_PSC, 32'h0000_FFFF);
    wr(tseg_pkg::A_STAT, 32'h0000_FFFF);
    t_reset();
    t_brake();
    t_trigger();
    t_channels();
    t_update();
    t_capture();
    t_commute();
    end_of_test();
  end
endmodule // tb_timer_software_event_gen
`default_nettype wire
